// [design/xad_params.svh]
// Purpose: Offsets, field positions, reset values and ranges of the XRAM access decode
// Assumes: Included by bare name from the design files
// Notes: Definitions only
`ifndef XAD_PARAMS_SVH
`define XAD_PARAMS_SVH

// Special function register offsets on the core's register port
`define XAD_PAGE_OFS 8'h91
`define XAD_SYSCTL_OFS 8'hB1
`define XAD_UPORT_OFS 8'hA0

// Reset values
`define XAD_PAGE_RST 8'h00
`define XAD_UPORT_RST 8'hFF
`define XAD_DIS_RST 1'b1
`define XAD_VIS_RST 1'b0

// Field positions in the system control register
`define XAD_DIS_BIT 0
`define XAD_VIS_BIT 1

// XRAM window at the top of the 64 Kbyte data space
`define XAD_XRAM_BASE 16'hF800
`define XAD_XRAM_PAGE 8'hF8
`define XAD_XRAM_AW 11
`define XAD_XRAM_WORDS 2048

`endif

// [design/xad_pkg.sv]
// Purpose: Types shared by the XRAM access decode
// Assumes: Constants live in xad_params.svh
// Notes: All state of the top module is one packed struct
package xad_pkg;

  typedef enum logic [1:0] {
    XAD_IDLE = 2'b00,
    XAD_CYC1 = 2'b01,
    XAD_CYC2 = 2'b10
  } xad_state_e;

  // Port and strobe usage for one move
  typedef struct packed {
    logic ad_bus;
    logic ua_bus;
    logic strobe;
    logic internal;
  } xad_use_s;

  typedef struct packed {
    xad_state_e state;
    logic [7:0] page;
    logic [7:0] uport;
    logic dis;
    logic vis;
    logic [7:0] sfr_rdata;
    logic write;
    logic [15:0] addr;
    logic [7:0] wdata;
    xad_use_s use_;
    logic [7:0] ad_out;
    logic ad_oe;
    logic [7:0] ua_out;
    logic ua_oe;
    logic rd_n;
    logic wr_n;
    logic ale;
    logic [7:0] mv_rdata;
    logic mv_done;
  } xad_regs_s;

endpackage : xad_pkg

// [design/xad_xram.sv]
// Purpose: On-chip XRAM array with registered read
// Assumes: Write enable is already qualified by the move sequencer
// Notes: No reset on purpose, contents survive a system reset
`timescale 1ns/1ps
`include "xad_params.svh"
module xad_xram #(
  parameter int AW = `XAD_XRAM_AW,
  parameter int WORDS = `XAD_XRAM_WORDS
) (
  input wire logic clock,
  input wire logic we,
  input wire logic [AW-1:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata
);

  logic [7:0] mem [0:WORDS-1];

  // Reset does not reach the array, so stored values persist
  always_ff @(posedge clock) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end

endmodule : xad_xram

// [design/xad_decode.sv]
// Purpose: Steers external-data moves to the on-chip XRAM or the external multiplexed bus
// Assumes: Core issues one move at a time with mv_start and waits for mv_done
// Notes: Each move takes two cycles; register port is the core's SFR port
`timescale 1ns/1ps
`include "xad_params.svh"
module xad_decode
  import xad_pkg::*;
#(
  parameter int AW = `XAD_XRAM_AW,
  parameter int WORDS = `XAD_XRAM_WORDS
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  input wire logic mv_start,
  input wire logic mv_write,
  input wire logic mv_wide,
  input wire logic [15:0] data_pointer_16,
  input wire logic [7:0] indirect_pointer_register,
  input wire logic [7:0] acc_wdata,
  output logic [7:0] mv_rdata,
  output logic mv_done,
  input wire logic external_program_select_pin,
  input wire logic [7:0] ad_latch,
  input wire logic [7:0] ad_latch_oe,
  input wire logic [7:0] ad_in,
  output logic [7:0] ad_out,
  output logic [7:0] ad_oe,
  output logic [7:0] ua_out,
  output logic [7:0] ua_oe,
  output logic rd_n,
  output logic wr_n,
  output logic ale,
  output logic [7:0] upper_port_latch,
  output logic [7:0] xram_page_register,
  output logic xram_disable_bit,
  output logic xram_bus_visible_bit
);

  xad_regs_s r_ff;
  xad_regs_s nxt_r;
  logic [7:0] xram_q;
  logic xram_we;
  logic [AW-1:0] xram_addr;
  logic [15:0] mv_addr;

  typedef enum logic [1:0] {
    XAD_SEL_NONE = 2'b00,
    XAD_SEL_PAGE = 2'b01,
    XAD_SEL_UPORT = 2'b10,
    XAD_SEL_SYSCTL = 2'b11
  } xad_sel_e;

  // Register select; the write and the read path share one decode
  function automatic xad_sel_e xad_sfr_sel(input logic [7:0] a);
    xad_sel_e s;
    if (a == `XAD_PAGE_OFS) begin
      s = XAD_SEL_PAGE;
    end else if (a == `XAD_UPORT_OFS) begin
      s = XAD_SEL_UPORT;
    end else if (a == `XAD_SYSCTL_OFS) begin
      s = XAD_SEL_SYSCTL;
    end else begin
      s = XAD_SEL_NONE;
    end
    return s;
  endfunction : xad_sfr_sel

  // System control image; reserved bits read as zero
  function automatic logic [7:0] xad_sysctl_image(input logic dis, input logic vis);
    logic [7:0] v;
    v = 8'h00;
    v[`XAD_DIS_BIT] = dis;
    v[`XAD_VIS_BIT] = vis;
    return v;
  endfunction : xad_sysctl_image

  // Window check: the pointer for wide moves, the page alone for indirect ones
  function automatic logic xad_in_window(input logic wide, input logic [15:0] ptr,
                                         input logic [7:0] page);
    logic hit;
    if (wide) begin
      hit = (ptr >= `XAD_XRAM_BASE);
    end else begin
      hit = (page >= `XAD_XRAM_PAGE);
    end
    return hit;
  endfunction : xad_in_window

  // Classifies a move into port usage, strobe activity and target
  function automatic xad_use_s xad_classify(input logic wide, input logic in_range,
                                            input logic dis, input logic vis,
                                            input logic pin);
    xad_use_s u;
    u.internal = in_range & ~dis;
    if (!u.internal) begin
      u.ad_bus = 1'b1;
      u.ua_bus = wide;
      u.strobe = 1'b1;
    end else if (vis) begin
      u.ad_bus = 1'b1;
      u.ua_bus = wide;
      u.strobe = 1'b1;
    end else begin
      // Pin high means the ports serve as I/O during a hidden XRAM access
      u.ad_bus = ~pin;
      u.ua_bus = wide & ~pin;
      u.strobe = 1'b0;
    end
    return u;
  endfunction : xad_classify

  // Full 16-bit pointer or page register above the indirect pointer
  assign mv_addr = mv_wide ? data_pointer_16 : {r_ff.page, indirect_pointer_register};

  always_comb begin
    logic in_range;
    xad_sel_e sel;
    in_range = 1'b0;
    sel = xad_sfr_sel(sfr_addr);
    nxt_r = r_ff;
    nxt_r.mv_done = 1'b0;
    nxt_r.ale = 1'b0;

    // Register port
    if (sfr_wr) begin
      if (sel == XAD_SEL_PAGE) begin
        nxt_r.page = sfr_wdata;
      end else if (sel == XAD_SEL_UPORT) begin
        nxt_r.uport = sfr_wdata;
        nxt_r.page = sfr_wdata;
      end else if (sel == XAD_SEL_SYSCTL) begin
        // Asymmetric latch: a write can clear but never set
        nxt_r.dis = r_ff.dis & sfr_wdata[`XAD_DIS_BIT];
        // Reserved bits of the system control register are not stored
        nxt_r.vis = sfr_wdata[`XAD_VIS_BIT];
      end
    end
    // A read and a write in one cycle return the old value
    if (sfr_rd) begin
      if (sel == XAD_SEL_PAGE) begin
        nxt_r.sfr_rdata = r_ff.page;
      end else if (sel == XAD_SEL_UPORT) begin
        nxt_r.sfr_rdata = r_ff.uport;
      end else if (sel == XAD_SEL_SYSCTL) begin
        nxt_r.sfr_rdata = xad_sysctl_image(r_ff.dis, r_ff.vis);
      end else begin
        nxt_r.sfr_rdata = 8'h00;
      end
    end

    case (r_ff.state)
      XAD_IDLE: begin
        if (mv_start) begin
          // Control bits are taken here; a later register write does not retarget the move
          in_range = xad_in_window(mv_wide, data_pointer_16, r_ff.page);
          nxt_r.state = XAD_CYC1;
          nxt_r.write = mv_write;
          nxt_r.addr = mv_addr;
          nxt_r.wdata = acc_wdata;
          nxt_r.use_ = xad_classify(mv_wide, in_range, r_ff.dis, r_ff.vis,
                                    external_program_select_pin);
          // Address phase
          if (nxt_r.use_.ad_bus) begin
            nxt_r.ad_out = mv_addr[7:0];
            nxt_r.ad_oe = 1'b1;
            nxt_r.ale = 1'b1;
          end
          if (nxt_r.use_.ua_bus) begin
            nxt_r.ua_out = mv_addr[15:8];
            nxt_r.ua_oe = 1'b1;
          end
        end
      end
      XAD_CYC1: begin
        nxt_r.state = XAD_CYC2;
        if (r_ff.use_.ad_bus) begin
          // Write data goes out even for XRAM writes when the bus is in use
          nxt_r.ad_out = r_ff.wdata;
          nxt_r.ad_oe = r_ff.write;
        end
        if (r_ff.use_.strobe) begin
          nxt_r.rd_n = r_ff.write;
          nxt_r.wr_n = ~r_ff.write;
        end
      end
      XAD_CYC2: begin
        nxt_r.state = XAD_IDLE;
        nxt_r.rd_n = 1'b1;
        nxt_r.wr_n = 1'b1;
        nxt_r.mv_done = 1'b1;
        // Read data is taken at the end of the strobe cycle, once the far side has settled
        if (!r_ff.write) begin
          nxt_r.mv_rdata = r_ff.use_.internal ? xram_q : ad_in;
        end
        nxt_r.use_ = '0;
      end
      default: begin
        nxt_r.state = XAD_IDLE;
      end
    endcase

    // Ports not in bus use follow their own latches
    // Drive value is parked at zero; the pin mux then shows the latch
    if (nxt_r.state == XAD_IDLE || !nxt_r.use_.ad_bus) begin
      nxt_r.ad_out = 8'h00;
      nxt_r.ad_oe = 1'b0;
    end
    // Indirect moves never put the page on the upper port, which stays free for I/O
    if (nxt_r.state == XAD_IDLE || !nxt_r.use_.ua_bus) begin
      nxt_r.ua_out = nxt_r.uport;
      nxt_r.ua_oe = 1'b1;
    end

    // Synchronous reset aborts a move in either cycle; the array write of the
    // second cycle is driven from the registered state and so still lands
    if (!reset_n) begin
      nxt_r.state = XAD_IDLE;
      nxt_r.page = `XAD_PAGE_RST;
      nxt_r.uport = `XAD_UPORT_RST;
      nxt_r.dis = `XAD_DIS_RST;
      nxt_r.vis = `XAD_VIS_RST;
      nxt_r.sfr_rdata = 8'h00;
      nxt_r.write = 1'b0;
      nxt_r.addr = 16'h0000;
      nxt_r.wdata = 8'h00;
      nxt_r.use_ = '0;
      nxt_r.ad_out = 8'h00;
      nxt_r.ad_oe = 1'b0;
      nxt_r.ua_out = `XAD_UPORT_RST;
      nxt_r.ua_oe = 1'b1;
      nxt_r.rd_n = 1'b1;
      nxt_r.wr_n = 1'b1;
      nxt_r.ale = 1'b0;
      nxt_r.mv_rdata = 8'h00;
      nxt_r.mv_done = 1'b0;
    end
  end

  // No reset term here; reset is folded into the next-state logic above
  always_ff @(posedge clock) begin
    r_ff <= nxt_r;
  end

  // Write commits at the end of the second cycle only
  assign xram_we = (r_ff.state == XAD_CYC2) & r_ff.write & r_ff.use_.internal;
  assign xram_addr = r_ff.addr[AW-1:0];

  // The array has no reset input, so a system reset leaves its contents alone
  xad_xram #(
    .AW(AW),
    .WORDS(WORDS)
  ) u_xram (
    .clock(clock),
    .we(xram_we),
    .addr(xram_addr),
    .wdata(r_ff.wdata),
    .rdata(xram_q)
  );

  // I/O use mixes the address port latch in per pin
  for (genvar g = 0; g < 8; g++) begin : g_ad_pin
    assign ad_out[g] = r_ff.ad_oe ? r_ff.ad_out[g] : ad_latch[g];
    assign ad_oe[g] = r_ff.ad_oe | ad_latch_oe[g];
  end
  assign ua_out = r_ff.ua_out;
  assign ua_oe = {8{r_ff.ua_oe}};
  assign rd_n = r_ff.rd_n;
  assign wr_n = r_ff.wr_n;
  assign ale = r_ff.ale;
  assign sfr_rdata = r_ff.sfr_rdata;
  assign mv_rdata = r_ff.mv_rdata;
  assign mv_done = r_ff.mv_done;
  // State views for the core and the port logic
  assign upper_port_latch = r_ff.uport;
  assign xram_page_register = r_ff.page;
  assign xram_disable_bit = r_ff.dis;
  assign xram_bus_visible_bit = r_ff.vis;

endmodule : xad_decode

// [test/xad_chk.sv]
// Purpose: Port-level checks of the XRAM access decode
// Assumes: Bound to xad_decode; moves start only while idle
// Notes: One clock domain, synchronous active-low reset
`timescale 1ns/1ps
`include "xad_params.svh"
module xad_chk (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  input wire logic mv_start,
  input wire logic mv_write,
  input wire logic mv_wide,
  input wire logic [15:0] data_pointer_16,
  input wire logic mv_done,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [7:0] ua_out,
  input wire logic [7:0] upper_port_latch,
  input wire logic [7:0] xram_page_register,
  input wire logic xram_disable_bit,
  input wire logic xram_bus_visible_bit
);
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  chk_done_latency: assert property (
    mv_done |-> $past(mv_start, 3)) else $error("done without start");
  chk_ext_strobes: assert property (
    mv_start && mv_wide && data_pointer_16 < `XAD_XRAM_BASE |->
    ##2 wr_n == !$past(mv_write, 2) && rd_n == $past(mv_write, 2))
    else $error("external strobes wrong");
  chk_disabled_ext: assert property (
    mv_start && xram_disable_bit |-> ##2 !(rd_n && wr_n))
    else $error("disabled move not external");
  chk_hit_visible: assert property (
    mv_start && mv_wide && data_pointer_16 >= `XAD_XRAM_BASE && !xram_disable_bit |->
    ##2 (rd_n && wr_n) == !$past(xram_bus_visible_bit, 2))
    else $error("strobes on hit wrong");
  chk_port_shadow: assert property (
    sfr_wr && sfr_addr == `XAD_UPORT_OFS |=> xram_page_register == $past(sfr_wdata)
    && upper_port_latch == $past(sfr_wdata)) else $error("port write not shadowed");
  chk_page_only: assert property (
    sfr_wr && sfr_addr == `XAD_PAGE_OFS |=> xram_page_register == $past(sfr_wdata)
    && $stable(upper_port_latch)) else $error("page write wrong");
  chk_dis_sticky: assert property (
    !xram_disable_bit |=> !xram_disable_bit) else $error("disable bit set again");
  chk_narrow_upper: assert property (
    mv_start && !mv_wide |-> ##1 (ua_out == upper_port_latch) [*2])
    else $error("upper port left I/O use");
endmodule : xad_chk
bind xad_decode xad_chk u_chk (.*);

// [test/xad_extmem.sv]
// Purpose: External data memory on the multiplexed bus
// Assumes: Low address latched by ale, high byte from the upper port
// Notes: Released data lines show the inverse of the last value
`timescale 1ns/1ps
module xad_extmem (
  input wire logic clock,
  input wire logic ale,
  input wire logic [7:0] ad_out,
  input wire logic [7:0] ua_out,
  input wire logic rd_n,
  input wire logic wr_n,
  output logic [7:0] ad_in
);
  logic [7:0] mem [0:65535];
  logic [7:0] lo_ff;
  logic [7:0] last_ff;
  always_ff @(posedge clock) begin
    if (ale) lo_ff <= ad_out;
    if (!wr_n) mem[{ua_out, lo_ff}] <= ad_out;
    last_ff <= ad_in;
  end
  assign ad_in = !rd_n ? mem[{ua_out, lo_ff}] : ~last_ff;
endmodule : xad_extmem

// [test/tb.sv]
// Purpose: Self-checking bench of the XRAM access decode
// Assumes: External memory model on the bus side
// Notes: Random moves from a fixed xorshift seed
`timescale 1ns/1ps
`include "xad_params.svh"
module tb;
  logic clock = 1'b0, reset_n = 1'b0, sfr_wr = 1'b0, sfr_rd = 1'b0, mv_start = 1'b0;
  logic mv_write = 1'b0, mv_wide = 1'b0, external_program_select_pin = 1'b0;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, indirect_pointer_register = 8'h00;
  logic [7:0] acc_wdata = 8'h00, ad_latch = 8'h5A, ad_latch_oe = 8'h00;
  logic [15:0] data_pointer_16 = 16'h0000;
  logic [15:0] a;
  logic [7:0] up = 8'hFF;
  logic [7:0] sfr_rdata, mv_rdata, ad_in, ad_out, ad_oe, ua_out, ua_oe, upper_port_latch;
  logic [7:0] xram_page_register;
  logic mv_done, rd_n, wr_n, ale, xram_disable_bit, xram_bus_visible_bit;
  logic [31:0] r = 32'h7564;
  int err_total = 0, compares = 0;
  xad_decode uut (.*);
  xad_extmem u_mem (.*);
  always #2.5 clock = ~clock;
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] t;
    t = v ^ (v << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs
  task automatic end_sim;
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_sim
  task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk
  task automatic sfr(input logic w, input logic [7:0] ad, input logic [7:0] d);
    sfr_addr = ad;
    sfr_wdata = d;
    sfr_wr = w;
    sfr_rd = !w;
    @(negedge clock);
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    @(negedge clock);
  endtask : sfr
  task automatic mv(input logic w, input logic wd, input logic [15:0] ad, input logic [7:0] d);
    int n;
    mv_write = w;
    mv_wide = wd;
    data_pointer_16 = ad;
    indirect_pointer_register = ad[7:0];
    acc_wdata = d;
    mv_start = 1'b1;
    @(negedge clock);
    mv_start = 1'b0;
    n = 0;
    while (mv_done !== 1'b1 && n < 8) begin
      @(negedge clock);
      n++;
    end
    if (n == 8) begin
      err_total++;
      end_sim();
    end
  endtask : mv
  // Reset lands in the first (k=0) or second (k=1) cycle of an XRAM write
  task automatic mv_rst(input int k);
    mv_write = 1'b1;
    mv_wide = 1'b1;
    data_pointer_16 = 16'hF840;
    acc_wdata = 8'h77;
    mv_start = 1'b1;
    @(negedge clock);
    mv_start = 1'b0;
    if (k == 1) @(negedge clock);
    reset_n = 1'b0;
    repeat (2) @(negedge clock);
    reset_n = 1'b1;
    chk("dis", xram_disable_bit, 1'b1);
    sfr(1'b1, `XAD_SYSCTL_OFS, 8'h00);
    mv(1'b0, 1'b1, 16'hF840, 8'h00);
    chk("rst wr", mv_rdata, k ? 8'h77 : 8'h11);
  endtask : mv_rst
  initial begin
    repeat (20) @(negedge clock);
    reset_n = 1'b1;
    chk("page", xram_page_register, 8'h00);
    chk("dis", xram_disable_bit, 1'b1);
    sfr(1'b0, 8'h33, 8'h00);
    chk("unmapped", sfr_rdata, 8'h00);
    sfr(1'b1, `XAD_UPORT_OFS, 8'h12);
    chk("page", xram_page_register, 8'h12);
    sfr(1'b1, `XAD_PAGE_OFS, 8'hF8);
    sfr(1'b0, `XAD_PAGE_OFS, 8'h00);
    chk("page rd", sfr_rdata, 8'hF8);
    chk("latch", upper_port_latch, 8'h12);
    mv(1'b1, 1'b1, 16'hF830, 8'h3C);
    chk("ext", u_mem.mem[16'hF830], 8'h3C);
    sfr(1'b1, `XAD_SYSCTL_OFS, 8'h00);
    sfr(1'b1, `XAD_SYSCTL_OFS, 8'h01);
    chk("dis", xram_disable_bit, 1'b0);
    mv(1'b1, 1'b1, 16'hF830, 8'hC3);
    mv(1'b0, 1'b1, 16'hF830, 8'h00);
    chk("xram", mv_rdata, 8'hC3);
    chk("ext", u_mem.mem[16'hF830], 8'h3C);
    sfr(1'b1, `XAD_UPORT_OFS, 8'hAA);
    mv(1'b1, 1'b0, 16'h0030, 8'h5E);
    chk("narrow ext", u_mem.mem[16'hAA30], 8'h5E);
    sfr(1'b1, `XAD_PAGE_OFS, 8'hF8);
    mv(1'b0, 1'b0, 16'h0030, 8'h00);
    chk("narrow xram", mv_rdata, 8'hC3);
    sfr(1'b1, `XAD_SYSCTL_OFS, 8'h02);
    mv(1'b1, 1'b1, 16'hF860, 8'hA5);
    chk("visible", u_mem.mem[16'hF860], 8'hA5);
    sfr(1'b1, `XAD_SYSCTL_OFS, 8'h00);
    chk("vis", xram_bus_visible_bit, 1'b0);
    mv(1'b1, 1'b1, 16'hF840, 8'h11);
    mv_rst(0);
    mv_rst(1);
    for (int i = 0; i < 24; i++) begin
      r = xs(r);
      external_program_select_pin = r[20];
      ad_latch = r[7:0];
      ad_latch_oe = r[15:8];
      a = i[0] ? {5'h1F, r[10:0]} : {1'b0, r[14:0]};
      up = i[0] ? up : a[15:8];
      sfr(1'b1, `XAD_SYSCTL_OFS, {6'h00, r[22], r[23]});
      sfr(1'b1, i[0] ? `XAD_PAGE_OFS : `XAD_UPORT_OFS, a[15:8]);
      mv(1'b1, r[21], a, r[31:24]);
      mv(1'b0, !r[21], a, 8'h00);
      chk("rand rd", mv_rdata, r[31:24]);
      chk("dis", xram_disable_bit, 1'b0);
      chk("ad io", ad_out, ad_latch);
      chk("ad oe", ad_oe, ad_latch_oe);
      chk("ua io", ua_out, up);
      chk("ua oe", ua_oe, 8'hFF);
    end
    end_sim();
  end
endmodule : tb
